// ---- design/brw_consts.svh ----
// Offsets, field positions, reset values and timing counts of the button and watchdog supervisor
`ifndef BRW_CONSTS_SVH
`define BRW_CONSTS_SVH

// Clock and derived timing
`define BRW_CLK_NS          40
`define BRW_PULSE_NS        128000
`define BRW_PULSE_CYC       ((`BRW_PULSE_NS + `BRW_CLK_NS - 1) / `BRW_CLK_NS)
`define BRW_TICK_NS         1000000
`define BRW_TICK_CYC        (`BRW_TICK_NS / `BRW_CLK_NS)
`define BRW_WD_S            14
`define BRW_WD_MS           (`BRW_WD_S * 1000)
`define BRW_LP_MS           8000
`define BRW_OFF_MS          500
`define BRW_DB_MS           20
`define BRW_WARN_STEP_MS    500

// Register byte offsets
`define BRW_OFF_CTRL        8'h00
`define BRW_OFF_FLAG        8'h04
`define BRW_OFF_MASK        8'h08
`define BRW_OFF_STATE       8'h0c

// Control register fields
`define BRW_CTRL_ACT_LSB    0
`define BRW_CTRL_VIN        2
`define BRW_CTRL_WDEN       3
`define BRW_CTRL_PCREQ      4
`define BRW_CTRL_WARN_LSB   5
`define BRW_CTRL_DBL        7
`define BRW_CTRL_ACT_MSK    8'h03
`define BRW_CTRL_PCREQ_MSK  8'h10
`define BRW_CTRL_RST        8'h00

// Flag and mask fields
`define BRW_NFLAG           5
`define BRW_FL_WARN         0
`define BRW_FL_DONE         1
`define BRW_FL_ILIM         2
`define BRW_FL_SDRP         3
`define BRW_FL_IDRP         4
`define BRW_MASK_RST        5'h00

// Pin synchroniser reset image, button idles high
`define BRW_PIN_RST         8'h80

`endif

// ---- design/brw_pkg.sv ----
// Types shared by the button and watchdog supervisor
package brw_pkg;

   // Long-press action selection
   typedef enum logic [1:0] {
      BRW_ACT_CYCLE = 2'b00,
      BRW_ACT_SHIP  = 2'b01,
      BRW_ACT_NONE  = 2'b10
   } brw_action_t;

   // Power-cycle sequencer
   typedef enum logic [0:0] {
      BRW_PC_IDLE = 1'b0,
      BRW_PC_OFF  = 1'b1
   } brw_pc_state_t;

   // Charger loop status pins
   typedef struct packed {
      logic charge_term;
      logic input_limit;
      logic system_droop;
      logic input_droop;
   } brw_chg_in_t;

   // Open-drain interrupt pin
   typedef struct packed {
      logic o;
      logic oe;
   } brw_int_pin_t;

   // Controls towards rails and charger
   typedef struct packed {
      logic system_rail_en;
      logic logic_rail_en;
      logic ship_mode;
      logic charge_pause;
      logic reduced_current;
      logic safety_double;
      logic safety_reset;
   } brw_chg_ctl_t;

endpackage

// ---- design/brw_top.sv ----
// Long-press button, adapter watchdog and interrupt pulse supervisor with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "brw_consts.svh"

// Summary of operation
// - Long press ends in power cycle, ship mode or nothing, per action select.
// - Timer runs while button low; on expiry the action happens at once.
// - Warning flag and interrupt come a lead time before long-press expiry.
// - During a press, changes to power cycle from another action are refused.
// - With input qualification on, press cycles only if adapter valid throughout.
// - Power-cycle request bit starts a cycle; logic rail stays on always.
// - Enabled watchdog cycles power if no bus access 14 s after adapter connect.
// - A bus access inside the 14 s window cancels the pending cycle.
// - Watchdog is off after reset and runs only once software enables it.
// - No interrupt pulses unless start-up completed into a valid state.
// - Interrupt pin idles released and pulls low 128 us per event.
// - Each source has a mask; masked triggers give no pulse.
// - Unmasking during a present condition gives no pulse; only new edges do.
// - Charge done flags and interrupts, pauses charging, resets safety timer.
// - Loop flags set on rising activity; current reduced, safety timer may double.
// - Button flag holds until cleared; no new button interrupt while set.
module brw_top #(
   parameter int unsigned TICK_CYC = `BRW_TICK_CYC,
   parameter int unsigned LP_MS    = `BRW_LP_MS,
   parameter int unsigned OFF_MS   = `BRW_OFF_MS,
   parameter int unsigned WD_MS    = `BRW_WD_MS
) (
   input  wire logic                  clk_sys,
   input  wire logic                  reset_n,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic [31:0]                hrdata,
   output logic                       hresp,
   input  wire logic                  button_input,
   input  wire logic                  adapter_valid,
   input  wire logic                  charge_en,
   input  wire logic                  recharge_threshold,
   input  wire brw_pkg::brw_chg_in_t  chg_loops,
   input  wire logic                  startup_ok,
   output brw_pkg::brw_int_pin_t      int_pin,
   output logic                       irq,
   output brw_pkg::brw_chg_ctl_t      chg_ctl
);
   import brw_pkg::*;

   // Bus sizes are all word accesses here, so hsize carries no decode
   logic [7:0]           pin_meta;
   logic [7:0]           pin_sync;
   logic [7:0]           pin_prev;
   logic [31:0]          tick_cnt;
   logic [7:0]           db_cnt;
   logic                 btn_db;
   logic                 btn_db_q;
   logic [31:0]          press_ms;
   logic [31:0]          lp_lim;
   logic [31:0]          warn_at;
   logic                 lp_done;
   logic                 vin_whole;
   logic [7:0]           ctrl;
   brw_pc_state_t        pc_state;
   logic [31:0]          pc_ms;
   logic                 wd_run;
   logic [15:0]          wd_ms;
   logic [`BRW_NFLAG-1:0] flag;
   logic [`BRW_NFLAG-1:0] mask;
   logic [11:0]          pulse_cnt;
   logic                 pulse_pend;
   logic [7:0]           dp_addr;
   logic                 dp_wr;
   logic                 dp_rd;

   // Warning lead time grows in fixed steps with the select code
   function automatic logic [31:0] brw_lead_ms(input logic [1:0] sel);
      brw_lead_ms = 32'(({30'h0, sel} + 32'h1) * `BRW_WARN_STEP_MS);
   endfunction

   // Synchronised pin views; first stage is read only by the second
   wire          btn_s  = pin_sync[7];
   wire          adp_s  = pin_sync[6];
   wire          ce_s   = pin_sync[5];
   wire          rch_s  = pin_sync[4];
   wire brw_chg_in_t loops_s = brw_chg_in_t'(pin_sync[3:0]);
   wire brw_chg_in_t loops_p = brw_chg_in_t'(pin_prev[3:0]);
   wire          adp_p  = pin_prev[6];
   wire          ce_p   = pin_prev[5];

   // Control register fields
   wire brw_action_t act = brw_action_t'(ctrl[`BRW_CTRL_ACT_LSB +: 2]);
   wire          needs_vin = ctrl[`BRW_CTRL_VIN];
   wire          wd_en     = ctrl[`BRW_CTRL_WDEN];
   wire [1:0]    warn_sel  = ctrl[`BRW_CTRL_WARN_LSB +: 2];
   wire          dbl_en    = ctrl[`BRW_CTRL_DBL];

   // Millisecond tick shared by every slow timer
   wire tick = (tick_cnt == TICK_CYC - 32'h1);

   // Button debounce: a new level must hold for the full debounce span
   wire db_diff = (btn_s != btn_db);
   wire db_take = db_diff & tick & (db_cnt == 8'(`BRW_DB_MS - 1));

   // Long-press timing; limits are latched at press start so mid-press edits wait
   wire        pressed     = ~btn_db;
   wire        press_start = btn_db_q & ~btn_db;
   wire        lp_live     = ~btn_db & ~btn_db_q & ~lp_done;
   wire [31:0] ms_next     = press_ms + 32'h1;
   wire [31:0] lead        = brw_lead_ms(warn_sel);
   wire [31:0] next_warn_at = (LP_MS > lead) ? (32'(LP_MS) - lead) : 32'h1;
   wire        warn_hit    = lp_live & tick & (ms_next == warn_at);
   wire        lp_expire   = lp_live & tick & (ms_next == lp_lim);
   wire        vin_ok      = vin_whole & adp_s;
   wire        lp_cycle    = lp_expire & (act == BRW_ACT_CYCLE) & (~needs_vin | vin_ok);
   wire        lp_ship     = lp_expire & (act == BRW_ACT_SHIP);

   // AHB-Lite decode; every accepted transfer counts as host activity
   wire        bus_txn  = hsel & htrans[1] & hready;
   wire        wr_ctrl  = dp_wr & (dp_addr == `BRW_OFF_CTRL);
   wire        wr_flag  = dp_wr & (dp_addr == `BRW_OFF_FLAG);
   wire        wr_mask  = dp_wr & (dp_addr == `BRW_OFF_MASK);
   wire [1:0]  wr_act   = hwdata[`BRW_CTRL_ACT_LSB +: 2];
   wire        act_block = lp_live & (wr_act == BRW_ACT_CYCLE) & (act != BRW_ACT_CYCLE);
   wire [7:0]  act_src  = act_block ? ctrl : hwdata[7:0];
   wire [7:0]  next_ctrl = wr_ctrl ?
      ((hwdata[7:0] & ~(`BRW_CTRL_PCREQ_MSK | `BRW_CTRL_ACT_MSK)) |
       (act_src & `BRW_CTRL_ACT_MSK)) : ctrl;
   wire        pcreq_wr = wr_ctrl & hwdata[`BRW_CTRL_PCREQ];

   // Adapter watchdog; a host access in the window cancels the cycle
   wire adp_rise = adp_s & ~adp_p;
   wire adp_fall = ~adp_s & adp_p;
   wire wd_fire  = wd_en & wd_run & tick & ~bus_txn & ~adp_fall &
                   (wd_ms == 16'(WD_MS - 1));

   // Power-cycle sequencer; later requests while off are absorbed
   wire           pc_start = lp_cycle | pcreq_wr | wd_fire;
   wire           pc_end   = tick & (pc_ms == OFF_MS - 32'h1);
   brw_pc_state_t next_pc_state;
   always_comb begin
      unique case (pc_state)
         BRW_PC_IDLE: next_pc_state = pc_start ? BRW_PC_OFF : BRW_PC_IDLE;
         BRW_PC_OFF:  next_pc_state = pc_end ? BRW_PC_IDLE : BRW_PC_OFF;
      endcase
   end

   // Events are edges only, so a condition already present at unmask stays quiet
   wire [`BRW_NFLAG-1:0] ev;
   assign ev[`BRW_FL_WARN] = warn_hit & ~flag[`BRW_FL_WARN];
   assign ev[`BRW_FL_DONE] = loops_s.charge_term & ~loops_p.charge_term;
   assign ev[`BRW_FL_ILIM] = loops_s.input_limit & ~loops_p.input_limit;
   assign ev[`BRW_FL_SDRP] = loops_s.system_droop & ~loops_p.system_droop;
   assign ev[`BRW_FL_IDRP] = loops_s.input_droop & ~loops_p.input_droop;
   wire [`BRW_NFLAG-1:0] w1c = wr_flag ? hwdata[`BRW_NFLAG-1:0] : '0;
   wire [`BRW_NFLAG-1:0] next_flag = (flag & ~w1c) | ev;   // Set wins over clear
   wire [`BRW_NFLAG-1:0] next_mask = wr_mask ? hwdata[`BRW_NFLAG-1:0] : mask;
   wire trig = startup_ok & (|(ev & ~mask));
   wire pulse_last = (pulse_cnt == 12'(`BRW_PULSE_CYC - 1));

   // Charge pause lasts until an input or enable toggle or recharge level
   wire pause_clr  = (adp_s ^ adp_p) | (ce_s ^ ce_p) | rch_s;
   wire next_pause = ev[`BRW_FL_DONE] | (chg_ctl.charge_pause & ~pause_clr);
   wire loop_any   = loops_s.input_limit | loops_s.system_droop | loops_s.input_droop;

   // Register read image
   wire [7:0] ctrl_rd  = ctrl | ((pc_state == BRW_PC_OFF) ? `BRW_CTRL_PCREQ_MSK : 8'h00);
   wire [7:0] state_rd = {2'h0, startup_ok, wd_run, pc_state == BRW_PC_OFF, lp_done,
                          pressed, adp_s};
   wire [31:0] rd_val =
      (dp_addr == `BRW_OFF_CTRL)  ? {24'h0, ctrl_rd} :
      (dp_addr == `BRW_OFF_FLAG)  ? {27'h0, flag} :
      (dp_addr == `BRW_OFF_MASK)  ? {27'h0, mask} :
      (dp_addr == `BRW_OFF_STATE) ? {24'h0, state_rd} : 32'h0;

   // Two-stage pin synchroniser plus one edge-history stage
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta <= `BRW_PIN_RST;
         pin_sync <= `BRW_PIN_RST;
         pin_prev <= `BRW_PIN_RST;
      end else begin
         pin_meta <= {button_input, adapter_valid, charge_en, recharge_threshold, chg_loops};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // Tick prescaler and button debounce
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt <= 32'h0;
         db_cnt   <= 8'h0;
         btn_db   <= 1'b1;
         btn_db_q <= 1'b1;
      end else begin
         tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
         db_cnt   <= (!db_diff || db_take) ? 8'h0 : (tick ? db_cnt + 8'h1 : db_cnt);
         btn_db   <= db_take ? btn_s : btn_db;
         btn_db_q <= btn_db;
      end
   end

   // Long-press timer; lp_done starts set so no action fires before a real press
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         press_ms  <= 32'h0;
         lp_lim    <= 32'h0;
         warn_at   <= 32'h0;
         lp_done   <= 1'b1;
         vin_whole <= 1'b0;
      end else if (press_start) begin
         press_ms  <= 32'h0;
         lp_lim    <= 32'(LP_MS);
         warn_at   <= next_warn_at;
         lp_done   <= 1'b0;
         vin_whole <= adp_s;
      end else begin
         press_ms  <= (lp_live & tick) ? ms_next : press_ms;
         lp_done   <= lp_done | lp_expire;
         vin_whole <= vin_whole & ~(pressed & ~adp_s);
      end
   end

   // Watchdog window; only armed by an adapter connect after enable
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wd_run <= 1'b0;
         wd_ms  <= 16'h0;
      end else if (!wd_en || adp_fall || wd_fire) begin
         wd_run <= 1'b0;
      end else if (adp_rise) begin
         wd_run <= 1'b1;
         wd_ms  <= 16'h0;
      end else if (bus_txn) begin
         wd_run <= 1'b0;
      end else if (wd_run && tick) begin
         wd_ms  <= wd_ms + 16'h1;
      end
   end

   // Power-cycle sequencer state and off-time counter
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pc_state <= BRW_PC_IDLE;
         pc_ms    <= 32'h0;
      end else begin
         pc_state <= next_pc_state;
         pc_ms    <= (pc_state == BRW_PC_IDLE) ? 32'h0 : (tick ? pc_ms + 32'h1 : pc_ms);
      end
   end

   // Control, flag and mask registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= `BRW_CTRL_RST;
         flag <= '0;
         mask <= `BRW_MASK_RST;
      end else begin
         ctrl <= next_ctrl;
         flag <= next_flag;
         mask <= next_mask;
      end
   end

   // Interrupt pulse; an event during a pulse queues one more after a released cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         int_pin    <= '0;
         pulse_cnt  <= 12'h0;
         pulse_pend <= 1'b0;
         irq        <= 1'b0;
      end else begin
         irq      <= startup_ok & (|(next_flag & ~next_mask));
         int_pin.o <= 1'b0;
         if (!int_pin.oe) begin
            int_pin.oe <= trig | pulse_pend;
            pulse_cnt  <= 12'h0;
            pulse_pend <= 1'b0;
         end else begin
            int_pin.oe <= ~pulse_last;
            pulse_cnt  <= pulse_cnt + 12'h1;
            pulse_pend <= pulse_pend | trig;
         end
      end
   end

   // Rail and charger controls; logic rail is never dropped, even mid-cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         chg_ctl <= '{system_rail_en: 1'b1, logic_rail_en: 1'b1, default: 1'b0};
      end else begin
         chg_ctl.system_rail_en  <= (next_pc_state == BRW_PC_IDLE);
         chg_ctl.logic_rail_en   <= 1'b1;
         chg_ctl.ship_mode       <= chg_ctl.ship_mode | lp_ship;
         chg_ctl.charge_pause    <= next_pause;
         chg_ctl.reduced_current <= loop_any;
         chg_ctl.safety_double   <= loop_any & dbl_en;
         chg_ctl.safety_reset    <= ev[`BRW_FL_DONE];
      end
   end

   // AHB-Lite slave: writes land at end of data phase, reads take one wait state
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dp_addr   <= 8'h0;
         dp_wr     <= 1'b0;
         dp_rd     <= 1'b0;
         hreadyout <= 1'b1;
         hrdata    <= 32'h0;
         hresp     <= 1'b0;
      end else begin
         dp_addr   <= bus_txn ? haddr[7:0] : dp_addr;
         dp_wr     <= bus_txn & hwrite;
         dp_rd     <= bus_txn & ~hwrite;
         hreadyout <= ~(bus_txn & ~hwrite);
         hrdata    <= dp_rd ? rd_val : hrdata;
         hresp     <= 1'b0;
      end
   end

   // Checks on the supervisor's own behaviour
   default clocking brw_cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   a_ship_on_expire: assert property (lp_ship |=> chg_ctl.ship_mode)
      else $error("ship mode not entered on long press");
   a_cycle_on_expire: assert property (
      (lp_cycle && pc_state == BRW_PC_IDLE) |=> !chg_ctl.system_rail_en ##1 !chg_ctl.system_rail_en)
      else $error("power cycle not started on long press");
   a_warn_before_end: assert property (
      warn_hit |=> flag[`BRW_FL_WARN] && !lp_done)
      else $error("warning flag missing before expiry");
   a_reject_cycle: assert property (
      (wr_ctrl && lp_live && act != BRW_ACT_CYCLE) |=> act != BRW_ACT_CYCLE)
      else $error("change to power cycle accepted during press");
   a_vin_gate: assert property (
      (lp_expire && needs_vin && !vin_ok && !pcreq_wr && !wd_fire &&
       pc_state == BRW_PC_IDLE) |=> chg_ctl.system_rail_en)
      else $error("power cycle without qualified input");
   a_logic_rail: assert property (
      (pcreq_wr && pc_state == BRW_PC_IDLE) |=>
         !chg_ctl.system_rail_en && chg_ctl.logic_rail_en)
      else $error("request bit cycle wrong or logic rail dropped");
   a_wd_fire: assert property (
      (wd_fire && pc_state == BRW_PC_IDLE) |=> pc_state == BRW_PC_OFF && !wd_run)
      else $error("watchdog expiry did not cycle power");
   a_wd_cancel: assert property (
      (wd_run && bus_txn && !adp_rise) |=> !wd_run [*2])
      else $error("bus access did not cancel watchdog");
   a_wd_disabled: assert property (!wd_en |=> !wd_run)
      else $error("watchdog ran while disabled");
   a_no_int_fault: assert property ($rose(int_pin.oe) |-> $past(startup_ok) || $past(pulse_pend))
      else $error("interrupt pulse without valid start-up");
   a_pulse_width: assert property (
      $fell(int_pin.oe) |-> $past(pulse_cnt) == 12'(`BRW_PULSE_CYC - 1) && !int_pin.o)
      else $error("interrupt pulse width wrong");
   a_masked_quiet: assert property (
      (!int_pin.oe && !pulse_pend && !trig) |=> !int_pin.oe)
      else $error("pulse from masked or absent trigger");
   a_done_pause: assert property (
      ev[`BRW_FL_DONE] |=> chg_ctl.charge_pause && chg_ctl.safety_reset &&
         flag[`BRW_FL_DONE])
      else $error("charge done response missing");
   a_warn_once: assert property (
      (flag[`BRW_FL_WARN] && !w1c[`BRW_FL_WARN]) |=> flag[`BRW_FL_WARN] && !ev[`BRW_FL_WARN])
      else $error("button flag dropped or re-sent");

endmodule // brw_top
`default_nettype wire

// ---- dv/brw_host_model.sv ----
// Host and pushbutton model: pulled-up interrupt line and button contact
`timescale 1ns/1ps
`default_nettype none
module brw_host_model (
   input  wire logic                  clk_sys,
   input  wire brw_pkg::brw_int_pin_t int_pin,
   input  wire logic                  press,
   output logic                       button_input,
   output logic                       int_n,
   output int unsigned                n_pulse,
   output int unsigned                last_width
);
   import brw_pkg::*;
   int unsigned width;

   // Open drain: released line floats to the pull-up, never holds a stale low
   assign int_n        = int_pin.oe ? int_pin.o : 1'b1;
   // Button pulls the pin low while pressed, pull-up otherwise
   assign button_input = press ? 1'b0 : 1'b1;

   // Count low pulses and keep the width of the last one
   initial begin
      n_pulse = 0;
      last_width = 0;
      width = 0;
   end
   always @(posedge clk_sys) begin
      if (int_n === 1'b0) begin
         width <= width + 1;
      end else if (width != 0) begin
         n_pulse    <= n_pulse + 1;
         last_width <= width;
         width      <= 0;
      end
   end
endmodule // brw_host_model
`default_nettype wire

// ---- dv/brw_top_bench.sv ----
// Self-checking bench of the button, watchdog and interrupt supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module brw_top_bench;
   import brw_pkg::*;
   localparam int unsigned TK = 10;
   localparam int unsigned PULSE = 3200;
   localparam int unsigned WD = 30;
   logic         clk_sys = 0, reset_n = 0, hsel = 0, hwrite = 0, press = 0;
   logic         adapter_valid = 0, charge_en = 0, recharge_threshold = 0, startup_ok = 0;
   logic [31:0]  haddr = 0, hwdata = 0, rdv;
   logic [1:0]   htrans = 0;
   logic [2:0]   hsize = 3'h2;
   brw_chg_in_t  chg_loops = '0;
   wire          hreadyout, hresp, irq, button_input, int_n;
   wire [31:0]   hrdata;
   brw_int_pin_t int_pin;
   brw_chg_ctl_t chg_ctl;
   int unsigned  n_pulse, last_width, n_fail = 0, num_checks = 0;
   logic         dropped;
   logic [95:0]  rows [6] = '{{32'h0, 32'hed, 32'hed}, {32'h8, 32'hffffffff, 32'h1f},
      {32'h10, 32'hff, 32'h0}, {32'h100, 32'h2, 32'h2}, {32'hc, 32'hff, 32'h24},
      {32'h8, 32'h0, 32'h0}};

   always #20 clk_sys = ~clk_sys;

   brw_top #(.TICK_CYC(TK), .LP_MS(40), .OFF_MS(4), .WD_MS(WD)) u_dut (.clk_sys(clk_sys),
      .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .button_input(button_input),
      .adapter_valid(adapter_valid), .charge_en(charge_en),
      .recharge_threshold(recharge_threshold), .chg_loops(chg_loops),
      .startup_ok(startup_ok), .int_pin(int_pin), .irq(irq), .chg_ctl(chg_ctl));
   brw_host_model u_host (.clk_sys(clk_sys), .int_pin(int_pin), .press(press),
      .button_input(button_input), .int_n(int_n), .n_pulse(n_pulse),
      .last_width(last_width));

   // One bus transfer; holds each phase until ready is sampled high
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0; hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      `CHK(rdv, e)
   endtask
   // Waits out one full pulse so the model has counted it
   task automatic pulses(input int unsigned e);
      repeat (PULSE + 200) @(posedge clk_sys);
      `CHK(n_pulse, e)
   endtask
   // Watches n cycles, noting any drop of the system rail
   task automatic watch(input int unsigned n);
      dropped = 1'b0;
      repeat (n) begin
         @(posedge clk_sys);
         if (chg_ctl.system_rail_en !== 1'b1) dropped = 1'b1;
      end
   endtask
   // Holds the button for n cycles under watch, then lets debounce settle
   task automatic hold(input int unsigned n);
      press <= 1'b1;
      watch(n);
      press <= 1'b0;
      repeat (400) @(posedge clk_sys);
   endtask
   task automatic test_done;
      if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Watchdog: generous bound over the whole sequence
   initial begin
      repeat (60000) @(posedge clk_sys);
      n_fail++;
      test_done();
   end

   initial begin
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      `CHK({hresp, hreadyout, int_pin, irq, chg_ctl}, 12'h460)
      rchk(32'h0, 32'h0);
      startup_ok <= 1'b1;
      foreach (rows[i]) begin
         xfer(1'b1, rows[i][95:64], rows[i][63:32]);
         rchk(rows[i][95:64], rows[i][31:0]);
      end
      // Loop flag pulses once with the documented width, then W1C clears the flag
      chg_loops.input_limit <= 1'b1;
      pulses(1);
      `CHK(last_width, PULSE)
      `CHK(irq, 1'b1)
      `CHK({chg_ctl.reduced_current, chg_ctl.safety_double}, 2'b10)
      rchk(32'h4, 32'h4);
      xfer(1'b1, 32'h4, 32'h4);
      rchk(32'h4, 32'h0);
      // Masked trigger, then unmask while still active: no pulse either way
      xfer(1'b1, 32'h8, 32'h8);
      chg_loops.system_droop <= 1'b1;
      pulses(1);
      `CHK(irq, 1'b0)
      xfer(1'b1, 32'h8, 32'h0);
      pulses(1);
      chg_loops.system_droop <= 1'b0;
      repeat (10) @(posedge clk_sys);
      chg_loops.system_droop <= 1'b1;
      pulses(2);
      // Start-up not valid: charge done flags but sends nothing
      xfer(1'b1, 32'h4, 32'h1f);
      startup_ok <= 1'b0;
      chg_loops.charge_term <= 1'b1;
      pulses(2);
      `CHK(chg_ctl.charge_pause, 1'b1)
      charge_en <= 1'b1;
      repeat (20) @(posedge clk_sys);
      `CHK(chg_ctl.charge_pause, 1'b0)
      startup_ok <= 1'b1;
      // Software power cycle: system rail drops, logic rail stays
      xfer(1'b1, 32'h0, 32'h10);
      repeat (3) @(posedge clk_sys);
      `CHK({chg_ctl.system_rail_en, chg_ctl.logic_rail_en}, 2'b01)
      rchk(32'h0, 32'h10);
      repeat (4 * TK + 20) @(posedge clk_sys);
      `CHK(chg_ctl.system_rail_en, 1'b1)
      // Press without adapter under qualification: warn only, no cycle
      xfer(1'b1, 32'h0, 32'h4);
      hold(800);
      `CHK(dropped, 1'b0)
      pulses(3);
      // Adapter valid throughout and flag still set: cycle, no new pulse
      adapter_valid <= 1'b1;
      repeat (20) @(posedge clk_sys);
      hold(800);
      `CHK(dropped, 1'b1)
      pulses(3);
      // Live press: change to power cycle refused, to ship accepted
      xfer(1'b1, 32'h4, 32'h1);
      xfer(1'b1, 32'h0, 32'h2);
      press <= 1'b1;
      repeat (300) @(posedge clk_sys);
      xfer(1'b1, 32'h0, 32'h0);
      rchk(32'h0, 32'h2);
      xfer(1'b1, 32'h0, 32'h1);
      repeat (500) @(posedge clk_sys);
      `CHK(chg_ctl.ship_mode, 1'b1)
      rchk(32'h4, 32'h3);
      press <= 1'b0;
      pulses(4);
      reset_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      `CHK(chg_ctl.ship_mode, 1'b0)
      rchk(32'h0, 32'h0);
      // Adapter watchdog: a silent host gets a cycle, an early access cancels it
      adapter_valid <= 1'b0;
      xfer(1'b1, 32'h0, 32'ha);
      repeat (5) @(posedge clk_sys);
      adapter_valid <= 1'b1;
      watch(WD * TK + 100);
      `CHK(dropped, 1'b1)
      adapter_valid <= 1'b0;
      repeat (5) @(posedge clk_sys);
      adapter_valid <= 1'b1;
      repeat (100) @(posedge clk_sys);
      rchk(32'h0, 32'ha);
      watch(WD * TK + 100);
      `CHK(dropped, 1'b0)
      test_done();
   end
endmodule // brw_top_bench
`default_nettype wire
